// [rtl/scs_pkg.sv]
// package of constants and carrier types for the conversion sequencer
package scs_pkg;
    // result word width and busy-bit extension
    localparam int unsigned RES_W      = 16;
    localparam int unsigned CNT_W      = 5;
    // clock rate and fixed conversion time
    localparam int unsigned CLK_MHZ    = 100;
    localparam int unsigned T_CONV_NS  = 1400;
    localparam int unsigned CONV_CYC   = (T_CONV_NS * CLK_MHZ) / 1000;
    localparam int unsigned TIMER_W    = 11;
    localparam logic [TIMER_W-1:0] CONV_LAST = TIMER_W'(CONV_CYC - 1);
    // result code landmarks, straight binary
    localparam logic [RES_W-1:0] CODE_ZERO = 16'h0000;
    localparam logic [RES_W-1:0] CODE_MID  = 16'h8000;
    localparam logic [RES_W-1:0] CODE_FULL = 16'hFFFF;
    localparam logic [CNT_W-1:0] BITS_PLAIN = 5'h10;
    localparam logic [CNT_W-1:0] BITS_BUSY  = 5'h11;

    // sequencer phases
    typedef enum logic [1:0] {
        SCS_ACQ,
        SCS_CONV,
        SCS_READ
    } scs_phase_e;

    // analog front end controls
    typedef struct packed {
        logic sample;     // pulse: capture difference on cap array
        logic isolate;    // inputs disconnected from internal circuits
        logic power_up;   // converter core powered
    } scs_afe_s;

    // serial output pin, two signals
    typedef struct packed {
        logic data;
        logic oe;
    } scs_pin_s;
endpackage

// [rtl/scs_sync.sv]
// two-flop synchroniser for one asynchronous level
`timescale 1ns/1ps
module scs_sync (
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    input  wire logic d_i,
    output logic      q_o
);
    logic meta_ff;
    logic q_ff;

    // =========================
    // sync stages
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_ff <= 1'b0;
            q_ff    <= 1'b0;
        end else begin
            meta_ff <= d_i;
            q_ff    <= meta_ff;
        end
    end

    assign q_o = q_ff;
endmodule // scs_sync

// [rtl/scs_sequencer.sv]
// conversion sequencer with serial result interface
// What this block does
// R1: conversion timed by internal fixed counter
// R2: sample input difference at conversion start
// R3: inputs isolated throughout conversion
// R4: reconnect capacitors, enter acquisition after conversion
// R5: acquisition powered down, result still readable
// R6: four variants: chip-select or chain, busy
// R7: busy enabled adds one leading bit
// R8: chain mode shifts serial input through
// R9: serial input high at start selects chip-select
// R10: start edge samples, converts, tristates output
// R11: next lower bit on each falling clock
// R12: straight binary result coding
// R13: host waits for conversion and readout
`timescale 1ns/1ps
module scs_sequencer (
    input  wire logic                    clk_i,
    input  wire logic                    arst_n_i,
    input  wire logic                    convert_start_i,
    input  wire logic                    serial_in_select_i,
    input  wire logic                    sclk_i,
    input  wire logic [scs_pkg::RES_W-1:0] conv_code_i,
    input  wire logic                    busy_en_i,
    output logic                         serial_result_out_o,
    output logic                         serial_result_out_oe_o,
    output logic                         sample_o,
    output logic                         isolate_o,
    output logic                         power_up_o,
    output logic                         chip_select_mode_o,
    output logic                         busy_o
);
    import scs_pkg::*;

    // =========================
    // reset release
    // deassertion is retimed so no flop leaves reset mid-setup window
    logic rst_a_ff;
    logic rst_n;
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rst_a_ff <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_a_ff <= 1'b1;
            rst_n    <= rst_a_ff;
        end
    end

    // =========================
    // pin synchronisers
    logic cs_s;
    logic sdi_s;
    logic sck_s;
    scs_sync u_sync_cs (
        .clk_i   (clk_i),
        .rst_n_i (rst_n),
        .d_i     (convert_start_i),
        .q_o     (cs_s)
    );
    scs_sync u_sync_sdi (
        .clk_i   (clk_i),
        .rst_n_i (rst_n),
        .d_i     (serial_in_select_i),
        .q_o     (sdi_s)
    );
    scs_sync u_sync_sck (
        .clk_i   (clk_i),
        .rst_n_i (rst_n),
        .d_i     (sclk_i),
        .q_o     (sck_s)
    );

    // =========================
    // state
    scs_phase_e             phase_ff,   nxt_phase;
    logic [TIMER_W-1:0]     timer_ff,   nxt_timer;
    logic [RES_W:0]         shift_ff,   nxt_shift;
    logic [CNT_W-1:0]       left_ff,    nxt_left;
    logic                   csm_ff,     nxt_csm;
    logic                   busy_ff,    nxt_busy;
    logic                   cs_d_ff,    sck_d_ff;
    scs_afe_s               afe_ff,     nxt_afe;
    scs_pin_s               pin_ff,     nxt_pin;

    logic cs_rise;
    logic cs_fall;
    logic sck_fall;
    assign cs_rise  = cs_s & ~cs_d_ff;
    assign cs_fall  = ~cs_s & cs_d_ff;
    assign sck_fall = ~sck_s & sck_d_ff;
    // edge flops reset to the idle pin levels, so no false edge after reset
    // the serial clock is sampled, so its period must span several clocks

    // read opens on start falling (chip-select) or serial input low (chain)
    logic open_cs;
    logic open_chain;
    assign open_cs    = csm_ff & cs_fall;
    assign open_chain = ~csm_ff & ~sdi_s & ~sck_fall & ~cs_s &
                        (left_ff == (busy_en_i ? BITS_BUSY : BITS_PLAIN));

    // next state of sequencer and shifter
    always_comb begin
        nxt_phase       = phase_ff;
        nxt_timer       = timer_ff;
        nxt_shift       = shift_ff;
        nxt_left        = left_ff;
        nxt_csm         = csm_ff;
        nxt_busy        = busy_ff;
        nxt_afe         = afe_ff;
        nxt_afe.sample  = 1'b0;
        nxt_pin         = pin_ff;
        case (phase_ff)
            SCS_ACQ, SCS_READ: begin
                // R13: host waits before restarting
                if (cs_rise) begin
                    // R9: mode strap at start edge
                    nxt_csm        = sdi_s;
                    // R2: capture input difference
                    nxt_afe.sample = 1'b1;
                    // R3: isolate inputs while converting
                    nxt_afe.isolate  = 1'b1;
                    nxt_afe.power_up = 1'b1;
                    // R10: output to high impedance
                    nxt_pin.oe     = 1'b0;
                    nxt_timer      = '0;
                    nxt_busy       = 1'b1;
                    nxt_phase      = SCS_CONV;
                end else if (phase_ff == SCS_READ) begin
                    // R11: next lower bit per falling clock
                    if (sck_fall && pin_ff.oe) begin
                        // chip-select mode stops after the last word bit
                        if (csm_ff && left_ff <= 5'h01) begin
                            nxt_pin.oe = 1'b0;
                            nxt_left   = '0;
                        end else begin
                            nxt_shift    = {shift_ff[RES_W-1:0], sdi_s};
                            // R8: chain passes serial input through
                            nxt_pin.data = shift_ff[RES_W];
                            // chain mode keeps driving, count parks at one
                            if (left_ff > 5'h01) begin
                                nxt_left = CNT_W'(left_ff - 5'h01);
                            end
                        end
                    end
                    // chip-select: start high ends the read
                    if (csm_ff && cs_s && pin_ff.oe) begin
                        nxt_pin.oe = 1'b0;
                    end
                    // read opens on start falling (chip-select) or serial input low (chain)
                    if (!pin_ff.oe && left_ff != '0 && (open_cs || open_chain)) begin
                        nxt_pin.oe   = 1'b1;
                        nxt_pin.data = shift_ff[RES_W];
                        nxt_shift    = {shift_ff[RES_W-1:0], 1'b0};
                    end
                end
            end
            SCS_CONV: begin
                // R1: fixed length on internal count
                if (timer_ff == CONV_LAST) begin
                    // R4: reconnect and acquire
                    nxt_afe.isolate  = 1'b0;
                    // R5: power down, result readable
                    nxt_afe.power_up = 1'b0;
                    nxt_busy         = 1'b0;
                    // R12: straight binary code loaded
                    // R7: busy adds leading one bit
                    // R6: variant sets framing
                    // without busy bit the low pad slot leaves ahead of
                    // the first chained bit in chain mode
                    if (busy_en_i) begin
                        nxt_shift = {1'b1, conv_code_i};
                        nxt_left  = BITS_BUSY;
                    end else begin
                        nxt_shift = {conv_code_i, 1'b0};
                        nxt_left  = BITS_PLAIN;
                    end
                    nxt_phase = SCS_READ;
                end else begin
                    nxt_timer = TIMER_W'(timer_ff + 11'h001);
                end
            end
            default: nxt_phase = SCS_ACQ;
        endcase
    end

    // register all state
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            phase_ff <= SCS_ACQ;
            timer_ff <= '0;
            shift_ff <= '0;
            left_ff  <= '0;
            csm_ff   <= 1'b1;
            busy_ff  <= 1'b0;
            cs_d_ff  <= 1'b0;
            sck_d_ff <= 1'b0;
            afe_ff   <= '0;
            pin_ff   <= '0;
        end else begin
            phase_ff <= nxt_phase;
            timer_ff <= nxt_timer;
            shift_ff <= nxt_shift;
            left_ff  <= nxt_left;
            csm_ff   <= nxt_csm;
            busy_ff  <= nxt_busy;
            cs_d_ff  <= cs_s;
            sck_d_ff <= sck_s;
            afe_ff   <= nxt_afe;
            pin_ff   <= nxt_pin;
        end
    end

    // outputs straight from flops
    assign serial_result_out_o    = pin_ff.data;
    assign serial_result_out_oe_o = pin_ff.oe;
    assign sample_o               = afe_ff.sample;
    assign isolate_o              = afe_ff.isolate;
    assign power_up_o             = afe_ff.power_up;
    assign chip_select_mode_o     = csm_ff;
    assign busy_o                 = busy_ff;
endmodule // scs_sequencer

// [test/scs_asserts.sv]
// checker of sequencer port timing
`timescale 1ns/1ps
module scs_asserts (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic convert_start_i,
    input wire logic serial_in_select_i,
    input wire logic serial_result_out_oe_o,
    input wire logic sample_o,
    input wire logic isolate_o,
    input wire logic power_up_o,
    input wire logic chip_select_mode_o,
    input wire logic busy_o
);
    import scs_pkg::*;
    logic [7:0] cnt_ff;
    logic [7:0] nxt_cnt;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);
    // ====
    // count cycles spent isolated
    always_comb nxt_cnt = isolate_o ? cnt_ff + 8'h01 : 8'h00;
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) cnt_ff <= 8'h00;
        else cnt_ff <= nxt_cnt;
    end
    sequence s_go;
        $rose(convert_start_i) && !isolate_o;
    endsequence
    sequence s_conv;
        sample_o && isolate_o ##1 !sample_o && isolate_o;
    endsequence
    property p_go; s_go |-> ##[2:6] s_conv; endproperty
    property p_len; $fell(isolate_o) |-> cnt_ff == 8'(CONV_CYC); endproperty
    property p_smp; $rose(isolate_o) |-> sample_o; endproperty
    property p_iso; isolate_o |-> !serial_result_out_oe_o; endproperty
    property p_acq; $fell(isolate_o) |-> !busy_o && !power_up_o ##1 !isolate_o[*8]; endproperty
    property p_pwr; power_up_o == isolate_o; endproperty
    property p_mode; $rose(sample_o) |=> chip_select_mode_o == $past(serial_in_select_i, 4);
    endproperty
    property p_off; $rose(convert_start_i) |-> ##[1:6] !serial_result_out_oe_o; endproperty
    property p_open; $fell(convert_start_i) && chip_select_mode_o && !isolate_o
        |-> ##[2:6] serial_result_out_oe_o; endproperty
    a_go: assert property (p_go) else $error("no conversion after start");
    a_len: assert property (p_len) else $error("wrong conversion length");
    a_smp: assert property (p_smp) else $error("no sample at start");
    a_iso: assert property (p_iso) else $error("output on while isolated");
    a_acq: assert property (p_acq) else $error("bad acquisition entry");
    a_pwr: assert property (p_pwr) else $error("power not tied to conversion");
    a_mode: assert property (p_mode) else $error("mode not captured");
    a_off: assert property (p_off) else $error("output not released");
    a_open: assert property (p_open) else $error("read not opened");
endmodule // scs_asserts
bind scs_sequencer scs_asserts u_chk (.clk_i, .arst_n_i, .convert_start_i,
    .serial_in_select_i, .serial_result_out_oe_o, .sample_o, .isolate_o,
    .power_up_o, .chip_select_mode_o, .busy_o);

// [test/scs_host_model.sv]
// host model: starts conversions and reads the serial word
`timescale 1ns/1ps
module scs_host_model (
    input  wire logic clk_i,
    input  wire logic sdo_i,
    output logic      convert_start_o,
    output logic      serial_in_select_o,
    output logic      sclk_o
);
    // ====
    // pins idle, serial clock still
    initial begin
        convert_start_o = 1'b0;
        serial_in_select_o = 1'b1;
        sclk_o = 1'b0;
    end
    // mode set ahead of the edge, conversion waited out
    task automatic convert(input logic cs);
        @(negedge clk_i);
        serial_in_select_o = cs;
        convert_start_o = 1'b0;
        repeat (4) @(negedge clk_i);
        convert_start_o = 1'b1;
        repeat (160) @(negedge clk_i);
    endtask
    // bit taken while clock high, one fall per bit
    task automatic read(input int n, output logic [16:0] w);
        w = 17'h0_0000;
        @(negedge clk_i);
        convert_start_o = 1'b0;
        repeat (10) @(negedge clk_i);
        for (int i = 0; i < n; i++) begin
            #3 sclk_o = 1'b1;
            #59.5 w = {w[15:0], sdo_i};
            sclk_o = 1'b0;
            #62.5;
        end
        repeat (10) @(negedge clk_i);
    endtask
endmodule // scs_host_model

// [test/tb_top.sv]
// self-checking bench for the conversion sequencer
`timescale 1ns/1ps
module tb_top;
    import scs_pkg::*;
    logic clk_i, arst_n_i, busy_en, sdo_d, sdo_oe, cs_mode, cst, ssel, sclk;
    logic [RES_W-1:0] code;
    wire serial_result_out = sdo_oe ? sdo_d : 1'bz;
    int num_errors = 0;
    int compares = 0;
    scs_host_model host (.clk_i, .sdo_i(serial_result_out), .convert_start_o(cst),
        .serial_in_select_o(ssel), .sclk_o(sclk));
    scs_sequencer dut (.clk_i, .arst_n_i, .convert_start_i(cst), .serial_in_select_i(ssel),
        .sclk_i(sclk), .conv_code_i(code), .busy_en_i(busy_en), .serial_result_out_o(sdo_d),
        .serial_result_out_oe_o(sdo_oe), .sample_o(), .isolate_o(), .power_up_o(),
        .chip_select_mode_o(cs_mode), .busy_o());
    // ====
    // clock
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    task automatic chk(input logic [16:0] got, input logic [16:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        chk({16'h0000, got}, {16'h0000, exp});
    endtask
    // code landmarks in chip-select mode
    task automatic t_codes();
        logic [16:0] w;
        logic [15:0] tbl [4] = '{16'h0000, 16'h8000, 16'h7FFF, 16'hFFFF};
        busy_en = 1'b0;
        foreach (tbl[i]) begin
            code = tbl[i];
            host.convert(1'b1);
            chk_bit(cs_mode, 1'b1);
            host.read(16, w);
            chk(w, {1'b0, tbl[i]});
            chk_bit(sdo_oe, 1'b0);
        end
    endtask
    // busy bit first, then a restart in mid-read
    task automatic t_busy();
        logic [16:0] w;
        busy_en = 1'b1;
        code = 16'h7FFF;
        host.convert(1'b1);
        host.read(17, w);
        chk(w, {1'b1, 16'h7FFF});
        code = 16'h1234;
        host.convert(1'b1);
        host.read(5, w);
        chk(w, 17'h0_0011);
        code = 16'hA5C3;
        host.convert(1'b1);
        host.read(17, w);
        chk(w, {1'b1, 16'hA5C3});
    endtask
    // chain mode: word then the low pad bit
    task automatic t_chain();
        logic [16:0] w;
        busy_en = 1'b0;
        code = 16'h00FF;
        host.convert(1'b0);
        chk_bit(cs_mode, 1'b0);
        host.read(17, w);
        chk(w, 17'h0_01FE);
    endtask
    task automatic results();
        if (num_errors == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // main sequence
    initial begin
        arst_n_i = 1'b0;
        busy_en = 1'b0;
        code = 16'h0000;
        repeat (20) @(negedge clk_i);
        arst_n_i = 1'b1;
        repeat (5) @(negedge clk_i);
        t_codes();
        t_busy();
        t_chain();
        results();
    end
    // watchdog
    initial begin
        #100000;
        num_errors++;
        results();
    end
endmodule // tb_top
